// File: test/hss_board.sv
/*
 Board model: strap resistors and pin wires of the four shared pins.
 Assumes the straps are held for the whole run of one reset cycle.
*/
`timescale 1ns/1ps
module hss_board (
   // Strap levels and sampler drive
   input  wire [3:0] strap,
   input  wire [3:0] o,
   input  wire [3:0] oe,
   // Resolved pins
   output wire [3:0] pin
);
   // Straps keep the pin level while undriven
   assign pin = (oe & o) | (~oe & strap);
endmodule

// File: test/hss_strap_sampler_chk.sv
/*
 Checker for the strap sampler ports.
 Assumes binding into every sampler instance.
*/
`timescale 1ns/1ps
module hss_strap_sampler_chk (
   input wire       clock,
   input wire       arst_n,
   input wire [3:0] o,
   input wire [3:0] oe,
   input wire [3:0] st,
   input wire       sv,
   input wire [4:0] md,
   input wire [1:0] pe,
   input wire [6:0] ad,
   input wire       hev
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   a_addr_bit3: assert property (ad[3] == 1'b1) else $error("addr bit3");
   a_mode_excl: assert property (sv |-> md[4] != md[3]) else $error("mode");
   a_stat_dn2: assert property (oe[0] |-> o[0] == $past(st[0])) else $error("dn2");
   a_stat_dn1: assert property (oe[1] |-> o[1] == $past(st[1])) else $error("dn1");
   a_stat_hs: assert property (oe[2] |-> o[2] == $past(st[2])) else $error("hs");
   a_stat_ss: assert property (oe[3] |-> o[3] == $past(st[3])) else $error("ss");
   a_gang_noport: assert property (md[2] |-> pe == 2'h0) else $error("gang");
   a_hub_gang: assert property (!md[2] |-> !hev) else $error("hub event");
   a_strap_hold: assert property (sv && $past(sv) |-> $stable(md) && $stable(ad))
      else $error("hold");
   a_oe_after: assert property ($rose(oe[0]) |-> $past(sv)) else $error("oe");
endmodule
bind hss_strap_sampler hss_strap_sampler_chk chk (.clock(clock), .arst_n(arst_n),
   .o({power_switching_disable_strap_o, slave_address_bit2_strap_o,
       power_control_polarity_strap_o, serial_bus_select_strap_o}),
   .oe({power_switching_disable_strap_oe, slave_address_bit2_strap_oe,
        power_control_polarity_strap_oe, serial_bus_select_strap_oe}),
   .st({upstream_superspeed_status, upstream_highspeed_status,
        port1_superspeed_status, port2_superspeed_status}),
   .sv(straps_valid), .pe(port_overcurrent_event), .ad(smbus_slave_address),
   .hev(hub_overcurrent_event),
   .md({i2c_master_mode, smbus_slave_mode, ganged_power_mode,
        power_switching_enabled, factory_test_mode}));

// File: test/hss_strap_sampler_test.sv
/*
 Bench: random straps over many resets, checked after capture.
 Assumes the board model resolves the four shared pins.
*/
`timescale 1ns/1ps
module hss_strap_sampler_test;
   reg         clock = 0;
   reg         arst_n = 0;
   reg  [4:0]  s = 0;
   reg  [3:0]  st = 0;
   reg  [1:0]  req = 0;
   integer     seed = 42;
   integer     err_count = 0;
   integer     compares = 0;
   integer     i;
   reg  [1:0]  ocn = 2'h3;
   reg  [3:0]  st_d = 0;
   reg  [16:0] q[$];
   reg  [16:0] e;
   reg  [16:0] ex;
   reg  [1:0]  pev_x;
   reg         hub_x;
   wire [3:0]  pin, o, oe;
   wire [1:0]  pwr, pev;
   wire        hev;
   wire [4:0]  md;
   wire [6:0]  ad;
   wire        sv, g;
   hss_board brd (.strap(s[3:0]), .o(o), .oe(oe), .pin(pin));
   hss_strap_sampler dut (.clock(clock), .arst_n(arst_n),
      .serial_bus_select_strap_i(pin[0]), .serial_bus_select_strap_o(o[0]),
      .serial_bus_select_strap_oe(oe[0]), .power_control_polarity_strap_i(pin[1]),
      .power_control_polarity_strap_o(o[1]), .power_control_polarity_strap_oe(oe[1]),
      .slave_address_bit2_strap_i(pin[2]), .slave_address_bit2_strap_o(o[2]),
      .slave_address_bit2_strap_oe(oe[2]), .power_switching_disable_strap_i(pin[3]),
      .power_switching_disable_strap_o(o[3]), .power_switching_disable_strap_oe(oe[3]),
      .test_mode_strap_i(s[4]), .port2_superspeed_status(st[0]),
      .port1_superspeed_status(st[1]), .upstream_highspeed_status(st[2]),
      .upstream_superspeed_status(st[3]), .port_power_request(req),
      .port_overcurrent_input_n(ocn), .port_power_switch_output(pwr),
      .port_overcurrent_event(pev), .hub_overcurrent_event(hev), .straps_valid(sv),
      .i2c_master_mode(md[4]), .smbus_slave_mode(md[3]), .ganged_power_mode(md[2]),
      .power_switching_enabled(md[1]), .factory_test_mode(md[0]),
      .smbus_slave_address(ad));
   initial forever #5 clock = ~clock;
   always @(posedge clock) begin
      st   <= $random(seed);
      st_d <= st;
   end
   task check(input string name, input [16:0] seen, input [16:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task tally_and_finish;
      if (err_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   assign g = s[2] & ~s[3];
   initial begin
      for (i = 0; i < 40; i = i + 1) begin
         @(posedge clock);
         arst_n <= 1'b0;
         s <= $random(seed);
         req <= $random(seed);
         ocn <= $random(seed);
         repeat (20) @(posedge clock);
         hub_x = g & ~(&ocn);
         pev_x = (s[3] | g) ? 2'h0 : ~ocn;
         e = {s[0], ~s[0], g, ~s[3], s[4], 3'h0, 1'b1, s[2], s[3], 1'b0,
              (s[3] ? 2'h0 : (g ? {2{|req & ~hub_x}} : req & ocn)) ^ {2{s[1]}},
              pev_x, hub_x};
         q.push_back(e);
         arst_n <= 1'b1;
         repeat (12) @(posedge clock);
      end
      check("pending", {16'h0, q.size() != 0}, 17'h0);
      tally_and_finish;
   end
   always @(posedge sv) begin
      @(negedge clock);
      check("pins_early", {13'h0, oe}, 17'h0);
      repeat (5) @(negedge clock);
      ex = q.pop_front();
      check("config", {md, ad, pwr, pev, hev}, ex);
      check("status", {9'h0, oe, o}, {9'h0, 4'hf, st_d});
   end
   initial begin
      #100000;
      err_count = err_count + 1;
      tally_and_finish;
   end
endmodule

// File: verilog/hss_regs.vh
/*
 Strap sampler constants: strap polarities, fixed slave address bits,
 and the synchroniser/capture timing.
 Assumes inclusion by bare name from the design files.
*/
`ifndef HSS_REGS_VH
`define HSS_REGS_VH
`define HSS_MODE_SMBUS        1'b0
`define HSS_MODE_I2C          1'b1
`define HSS_POL_ACT_HIGH      1'b0
`define HSS_POL_ACT_LOW       1'b1
`define HSS_PSW_ENABLED       1'b0
`define HSS_GANG_INDIVIDUAL   1'b0
`define HSS_ADDR_BIT3_FIXED   1'b1
`define HSS_ADDR_W            7
`define HSS_ADDR_BASE         7'h00
`define HSS_SYNC_STAGES       2
`define HSS_CAPTURE_CYCLE     2'h2
`define HSS_STRAP_W           5
`endif

// File: verilog/hss_strap_sampler.v
/*
 Hub strap sampler: captures the multi-function configuration pins after
 reset release, then turns them into status outputs.
 Assumes straps are held stable around reset release; pin wires are
 resolved outside from the output enables.
*/
// Function
// R1 - Strap bus-select 1 makes the serial pins an I2C EEPROM master, 0 an SMBus slave port.
// R2 - The bus-select pin is captured at reset release and the board holds it meanwhile.
// R3 - After reset the bus-select pin drives the port 2 SuperSpeed status.
// R4 - The polarity strap makes both power-control outputs active high at 0, low at 1.
// R5 - After reset the polarity pin drives the port 1 SuperSpeed status.
// R6 - The grouping strap picks per-port at 0 or ganged at 1 only while switching is enabled.
// R7 - In SMBus mode slave address bit 2 comes from the captured grouping strap.
// R8 - Slave address bit 3 is always 1.
// R9 - After reset the grouping pin shows upstream high-speed connection.
// R10 - The power-management strap enables power switching at 0 and disables it at 1.
// R11 - Power-control outputs switch port power only while switching is enabled.
// R12 - In SMBus mode slave address bit 1 comes from the captured power-management strap.
// R13 - After reset the power-management pin shows upstream SuperSpeed connection.
// R14 - Test pin high at reset enters factory test mode; the board holds it low normally.
// R15 - A low over-current input is an event; in ganged mode either input is a hub event; the sampler flags none while switching is disabled.
// R16 - Captured straps stay constant until the next reset.
`timescale 1ns/1ps
`include "hss_regs.vh"
module hss_strap_sampler (
   // Clock and reset
   input  wire       clock,
   input  wire       arst_n,
   // Multi-function pins
   input  wire       serial_bus_select_strap_i,
   output wire       serial_bus_select_strap_o,
   output wire       serial_bus_select_strap_oe,
   input  wire       power_control_polarity_strap_i,
   output wire       power_control_polarity_strap_o,
   output wire       power_control_polarity_strap_oe,
   input  wire       slave_address_bit2_strap_i,
   output wire       slave_address_bit2_strap_o,
   output wire       slave_address_bit2_strap_oe,
   input  wire       power_switching_disable_strap_i,
   output wire       power_switching_disable_strap_o,
   output wire       power_switching_disable_strap_oe,
   input  wire       test_mode_strap_i,
   // Status from hub core
   input  wire       port2_superspeed_status,
   input  wire       port1_superspeed_status,
   input  wire       upstream_highspeed_status,
   input  wire       upstream_superspeed_status,
   // Power requests from hub core and over-current pins
   input  wire [1:0] port_power_request,
   input  wire [1:0] port_overcurrent_input_n,
   output wire [1:0] port_power_switch_output,
   output wire [1:0] port_overcurrent_event,
   output wire       hub_overcurrent_event,
   // Decoded configuration
   output wire       straps_valid,
   output wire       i2c_master_mode,
   output wire       smbus_slave_mode,
   output wire       ganged_power_mode,
   output wire       power_switching_enabled,
   output wire       factory_test_mode,
   output wire [6:0] smbus_slave_address
);
   localparam ST_SYNC = 2'h0;
   localparam ST_CAPT = 2'h1;
   localparam ST_RUN  = 2'h2;

   wire [4:0] pins_sync;
   wire [1:0] oc_sync_n;
   reg  [1:0] state_ff;
   reg  [1:0] nxt_state;
   reg  [1:0] cnt_ff;
   reg  [1:0] nxt_cnt;
   reg  [4:0] strap_ff;
   reg  [1:0] pwr_ff;
   reg  [1:0] nxt_pwr;
   reg  [1:0] oc_port_ff;
   reg        oc_hub_ff;
   reg        stat_ff;
   reg  [3:0] stat_o_ff;
   reg        valid_ff;
   reg        i2c_ff;
   reg        smbus_ff;
   reg        psw_ff;
   reg        gang_ff;
   reg        test_ff;

   // Active level of a power-control output under the captured polarity
   function drive_level;
      input on;
      input pol;
      begin
         drive_level = (pol == `HSS_POL_ACT_LOW) ? ~on : on;
      end
   endfunction

   // Power-management strap level that leaves switching on
   function switching_on;
      input psw_pin;
      begin
         switching_on = (psw_pin == `HSS_PSW_ENABLED);
      end
   endfunction

   hss_sync2 #(.W(5)) u_pin_sync (
      .clock  (clock),
      .arst_n (arst_n),
      .d      ({test_mode_strap_i, power_switching_disable_strap_i,
                slave_address_bit2_strap_i, power_control_polarity_strap_i,
                serial_bus_select_strap_i}),
      .q      (pins_sync)
   );

   hss_sync2 #(.W(2)) u_oc_sync (
      .clock  (clock),
      .arst_n (arst_n),
      .d      (port_overcurrent_input_n),
      .q      (oc_sync_n)
   );

   // Wait for the synchroniser to fill, capture once, then run
   always @* begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      case (state_ff)
         ST_SYNC: begin
            nxt_cnt = cnt_ff + 2'h1;
            if (cnt_ff == `HSS_CAPTURE_CYCLE - 2'h1) begin
               nxt_state = ST_CAPT;
            end
         end
         ST_CAPT: begin
            nxt_state = ST_RUN;
         end
         ST_RUN: begin
            nxt_state = ST_RUN;
         end
         default: begin
            nxt_state = ST_SYNC;
            nxt_cnt   = 2'h0;
         end
      endcase
   end

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= ST_SYNC;
         cnt_ff   <= 2'h0;
         strap_ff <= 5'h00;
         valid_ff <= 1'b0;
         i2c_ff   <= 1'b0;
         smbus_ff <= 1'b0;
         psw_ff   <= 1'b0;
         gang_ff  <= 1'b0;
         test_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         // Decoded configuration is registered once and then held
         if (state_ff == ST_CAPT) begin
            strap_ff <= pins_sync; // see R2 see R14 see R16
            valid_ff <= 1'b1;
            i2c_ff   <= (pins_sync[0] == `HSS_MODE_I2C); // see R1
            smbus_ff <= (pins_sync[0] == `HSS_MODE_SMBUS); // see R1
            psw_ff   <= switching_on(pins_sync[3]); // see R10
            gang_ff  <= switching_on(pins_sync[3]) &
                        (pins_sync[2] != `HSS_GANG_INDIVIDUAL); // see R6
            test_ff  <= pins_sync[4]; // see R14
         end
      end
   end

   assign straps_valid            = valid_ff;
   assign i2c_master_mode         = i2c_ff; // see R1
   assign smbus_slave_mode        = smbus_ff; // see R1
   assign power_switching_enabled = psw_ff; // see R10
   assign ganged_power_mode       = gang_ff; // see R6
   assign factory_test_mode       = test_ff; // see R14
   // Bits 2 and 1 from straps, bit 3 fixed
   assign smbus_slave_address = `HSS_ADDR_BASE |
      {3'h0, `HSS_ADDR_BIT3_FIXED, strap_ff[2], strap_ff[3], 1'b0}; // see R7 see R8 see R12

   // Power switching: ganged turns all ports on if any asks and no hub over-current is flagged
   always @* begin
      nxt_pwr = 2'h0;
      if (power_switching_enabled) begin // see R11
         if (ganged_power_mode) begin
            nxt_pwr = {2{|port_power_request & ~oc_hub_ff}};
         end else begin
            nxt_pwr = port_power_request & ~oc_port_ff;
         end
      end
   end

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pwr_ff     <= 2'h0;
         oc_port_ff <= 2'h0;
         oc_hub_ff  <= 1'b0;
         stat_ff    <= 1'b0;
         stat_o_ff  <= 4'h0;
      end else begin
         // Polarity applied before the flop so the pins change cleanly
         pwr_ff[0]  <= drive_level(nxt_pwr[0], strap_ff[1]); // see R4
         pwr_ff[1]  <= drive_level(nxt_pwr[1], strap_ff[1]); // see R4
         stat_ff    <= straps_valid;
         // Status levels reach the pins one cycle after the core shows them
         stat_o_ff  <= {4{straps_valid}} &
                       {upstream_superspeed_status, upstream_highspeed_status,
                        port1_superspeed_status, port2_superspeed_status};
         // Low input means over-current
         oc_port_ff <= (ganged_power_mode || !power_switching_enabled) ?
                       2'h0 : ~oc_sync_n; // see R15
         oc_hub_ff  <= ganged_power_mode & ~(&oc_sync_n); // see R15
      end
   end

   assign port_power_switch_output    = pwr_ff; // see R4 see R11
   assign port_overcurrent_event      = oc_port_ff;
   assign hub_overcurrent_event       = oc_hub_ff;

   // Pins become status outputs once straps are held
   assign serial_bus_select_strap_oe       = stat_ff; // see R3
   assign serial_bus_select_strap_o        = stat_o_ff[0]; // see R3
   assign power_control_polarity_strap_oe  = stat_ff; // see R5
   assign power_control_polarity_strap_o   = stat_o_ff[1]; // see R5
   assign slave_address_bit2_strap_oe      = stat_ff; // see R9
   assign slave_address_bit2_strap_o       = stat_o_ff[2]; // see R9
   assign power_switching_disable_strap_oe = stat_ff; // see R13
   assign power_switching_disable_strap_o  = stat_o_ff[3]; // see R13
endmodule

// File: verilog/hss_sync2.v
/*
 Two flip-flop synchroniser for a bus of pin levels.
 Assumes inputs asynchronous to clock; resets to zero.
*/
`timescale 1ns/1ps
module hss_sync2 #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         clock,
   input  wire         arst_n,
   // Data
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;
endmodule
